// ==== design/tlic_core.sv ====
`timescale 1ns/1ps
module tlic_core #(
	parameter int NUM_WAKE = 2
) (
	input  wire logic                  I_CORE_CLK,
	input  wire logic                  I_RST_N,
	input  wire logic [7:0]            I_SFR_ADDR,
	input  wire logic [7:0]            I_SFR_WDATA,
	input  wire logic                  I_SFR_WR,
	input  wire logic                  I_SFR_RD,
	output logic      [7:0]            O_SFR_RDATA,
	output logic                       O_SFR_HIT,
	input  wire logic [7:0]            I_BIT_ADDR,
	input  wire logic                  I_BIT_WDATA,
	input  wire logic                  I_BIT_WR,
	output logic                       O_BIT_RDATA,
	input  wire logic [11:0]           I_IRQ_SRC,
	input  wire logic                  I_CORE_HALTED,
	input  wire logic [NUM_WAKE-1:0]   I_WAKE_PIN,
	input  wire logic                  I_IRQ_ACK,
	input  wire logic                  I_RETI,
	output logic                       O_IRQ_REQ,
	output logic      [15:0]           O_IRQ_VECTOR,
	output logic      [1:0]            O_IRQ_LEVEL,
	output logic      [3:0]            O_IRQ_SRC_ID,
	output logic      [2:0]            O_IN_SERVICE,
	output logic                       O_WAKE
);
	logic [7:0]                interrupt_enable;
	logic [7:0]                priority_select_reg;
	logic [7:0]                secondary_enable_priority_reg;
	logic [7:0]                watchdog_control_reg;
	logic [7:0]                next_en;
	logic [7:0]                next_prio;
	logic [7:0]                next_en2;
	logic [7:0]                next_wdctl;
	logic [7:0]                rdata;
	logic [7:0]                next_rdata;
	logic                      hit;
	logic                      next_hit;
	logic                      bit_rdata;
	logic                      next_bit_rdata;
	logic [11:0]               src_en;
	logic [11:0]               src_upper;
	logic [11:0]               active;
	logic [2:0]                in_service;
	logic [2:0]                next_in_service;
	tlic_pkg::tlic_disp_type   state;
	tlic_pkg::tlic_disp_type   next_state;
	logic                      req;
	logic                      next_req;
	logic [1:0]                lvl;
	logic [1:0]                next_lvl;
	logic [3:0]                src_id;
	logic [3:0]                next_src_id;
	logic [15:0]               vec;
	logic [15:0]               next_vec;
	logic                      cand;
	logic [1:0]                cand_lvl;
	logic [3:0]                cand_idx;
	logic [NUM_WAKE-1:0]       wake_meta;
	logic [NUM_WAKE-1:0]       wake_sync;
	logic                      wake;
	logic                      next_wake;

	tlic_pick_if pick_pm ();
	tlic_pick_if pick_hi ();
	tlic_pick_if pick_lo ();
	tlic_poll_pick u_pick_pm (.pick(pick_pm));
	tlic_poll_pick u_pick_hi (.pick(pick_hi));
	tlic_poll_pick u_pick_lo (.pick(pick_lo));

	// register writes: byte port first, then a bit write on top of it
	always_comb begin
		next_en    = interrupt_enable;
		next_prio  = priority_select_reg;
		next_en2   = secondary_enable_priority_reg;
		next_wdctl = watchdog_control_reg;
		if (I_SFR_WR) begin
			case (I_SFR_ADDR)
				tlic_pkg::ADDR_EN:    next_en = I_SFR_WDATA;
				tlic_pkg::ADDR_PRIO:  next_prio = I_SFR_WDATA;
				// reserved bits hold their reset ones
				tlic_pkg::ADDR_EN2:   next_en2 = I_SFR_WDATA | tlic_pkg::EN2_FIXED;
				tlic_pkg::ADDR_WDCTL: next_wdctl = I_SFR_WDATA;
				default: ;
			endcase
		end
		// the secondary register has no bit addresses
		if (I_BIT_WR) begin
			case (I_BIT_ADDR & tlic_pkg::BIT_BASE_MASK)
				tlic_pkg::ADDR_EN:    next_en[I_BIT_ADDR[2:0]] = I_BIT_WDATA;
				tlic_pkg::ADDR_PRIO:  next_prio[I_BIT_ADDR[2:0]] = I_BIT_WDATA;
				tlic_pkg::ADDR_WDCTL: next_wdctl[I_BIT_ADDR[2:0]] = I_BIT_WDATA;
				default: ;
			endcase
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			interrupt_enable              <= tlic_pkg::RST_EN;
			priority_select_reg           <= tlic_pkg::RST_PRIO;
			secondary_enable_priority_reg <= tlic_pkg::RST_EN2;
			watchdog_control_reg          <= tlic_pkg::RST_WDCTL;
		end else begin
			interrupt_enable              <= next_en;
			priority_select_reg           <= next_prio;
			secondary_enable_priority_reg <= next_en2;
			watchdog_control_reg          <= next_wdctl;
		end
	end

	// read paths, one cycle behind the address
	always_comb begin
		next_hit   = I_SFR_RD;
		next_rdata = 8'h00;
		case (I_SFR_ADDR)
			tlic_pkg::ADDR_EN:    next_rdata = interrupt_enable;
			tlic_pkg::ADDR_PRIO:  next_rdata = priority_select_reg;
			tlic_pkg::ADDR_EN2:   next_rdata = secondary_enable_priority_reg;
			tlic_pkg::ADDR_WDCTL: next_rdata = watchdog_control_reg;
			default:              next_hit = 1'b0;
		endcase
		case (I_BIT_ADDR & tlic_pkg::BIT_BASE_MASK)
			tlic_pkg::ADDR_EN:    next_bit_rdata = interrupt_enable[I_BIT_ADDR[2:0]];
			tlic_pkg::ADDR_PRIO:  next_bit_rdata = priority_select_reg[I_BIT_ADDR[2:0]];
			tlic_pkg::ADDR_WDCTL: next_bit_rdata = watchdog_control_reg[I_BIT_ADDR[2:0]];
			default:              next_bit_rdata = 1'b0;
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rdata     <= 8'h00;
			hit       <= 1'b0;
			bit_rdata <= 1'b0;
		end else begin
			rdata     <= next_rdata;
			hit       <= next_hit;
			bit_rdata <= next_bit_rdata;
		end
	end

	// per-source enables and level selection
	always_comb begin
		src_en                       = 12'h000;
		src_upper                    = 12'h000;
		src_en[tlic_pkg::SRC_PM]     = secondary_enable_priority_reg[tlic_pkg::E2_PM];
		src_en[tlic_pkg::SRC_TK]     = secondary_enable_priority_reg[tlic_pkg::E2_TK];
		src_en[tlic_pkg::SRC_METER]  = secondary_enable_priority_reg[tlic_pkg::E2_METER];
		src_en[tlic_pkg::SRC_SI]     = secondary_enable_priority_reg[tlic_pkg::E2_SI];
		src_en[tlic_pkg::SRC_WDOG]   = watchdog_control_reg[tlic_pkg::WD_IRQ_EN];
		src_en[tlic_pkg::SRC_X0]     = interrupt_enable[tlic_pkg::EN_X0];
		src_en[tlic_pkg::SRC_T0]     = interrupt_enable[tlic_pkg::EN_T0];
		src_en[tlic_pkg::SRC_X1]     = interrupt_enable[tlic_pkg::EN_X1];
		src_en[tlic_pkg::SRC_T1]     = interrupt_enable[tlic_pkg::EN_T1];
		src_en[tlic_pkg::SRC_SP]     = interrupt_enable[tlic_pkg::EN_SP];
		src_en[tlic_pkg::SRC_T2]     = interrupt_enable[tlic_pkg::EN_T2];
		// spare source has no own enable, only the global one
		src_en[tlic_pkg::SRC_AUX]    = 1'b1;
		// a set priority bit lifts the source to the upper level
		src_upper[tlic_pkg::SRC_TK]    = secondary_enable_priority_reg[tlic_pkg::E2_TK_PRIO];
		src_upper[tlic_pkg::SRC_SI]    = secondary_enable_priority_reg[tlic_pkg::E2_SI_PRIO];
		src_upper[tlic_pkg::SRC_METER] = priority_select_reg[tlic_pkg::PR_METER];
		src_upper[tlic_pkg::SRC_X0]    = priority_select_reg[tlic_pkg::PR_X0];
		src_upper[tlic_pkg::SRC_T0]    = priority_select_reg[tlic_pkg::PR_T0];
		src_upper[tlic_pkg::SRC_X1]    = priority_select_reg[tlic_pkg::PR_X1];
		src_upper[tlic_pkg::SRC_T1]    = priority_select_reg[tlic_pkg::PR_T1];
		src_upper[tlic_pkg::SRC_SP]    = priority_select_reg[tlic_pkg::PR_SP];
		src_upper[tlic_pkg::SRC_T2]    = priority_select_reg[tlic_pkg::PR_T2];
	end

	// halted core takes no interrupts, only wake-ups; global bit gates all
	assign active = I_IRQ_SRC & src_en & {12{interrupt_enable[tlic_pkg::EN_GLOBAL] & ~I_CORE_HALTED}};
	assign pick_pm.mask = active & (12'h001 << tlic_pkg::SRC_PM);
	assign pick_hi.mask = active & src_upper & ~(12'h001 << tlic_pkg::SRC_PM);
	assign pick_lo.mask = active & ~src_upper & ~(12'h001 << tlic_pkg::SRC_PM);

	// a level wins only if nothing at or above it is in service
	always_comb begin
		cand     = 1'b0;
		cand_lvl = tlic_pkg::LVL_LOW;
		cand_idx = 4'h0;
		if (pick_pm.found && !in_service[tlic_pkg::LVL_PM]) begin
			cand     = 1'b1;
			cand_lvl = tlic_pkg::LVL_PM;
			cand_idx = pick_pm.idx;
		end else if (pick_hi.found && in_service[2:1] == 2'h0) begin
			cand     = 1'b1;
			cand_lvl = tlic_pkg::LVL_HIGH;
			cand_idx = pick_hi.idx;
		end else if (pick_lo.found && in_service == 3'h0) begin
			cand     = 1'b1;
			cand_lvl = tlic_pkg::LVL_LOW;
			cand_idx = pick_lo.idx;
		end
	end

	// request held toward the core; re-aimed each cycle until taken
	always_comb begin
		next_state      = state;
		next_req        = req;
		next_lvl        = lvl;
		next_src_id     = src_id;
		next_vec        = vec;
		next_in_service = in_service;
		// return releases the innermost level before any new entry
		if (I_RETI) begin
			if (in_service[2])
				next_in_service[2] = 1'b0;
			else if (in_service[1])
				next_in_service[1] = 1'b0;
			else
				next_in_service[0] = 1'b0;
		end
		case (state)
			tlic_pkg::DISP_IDLE: begin
				next_req = cand;
				if (cand)
					next_state = tlic_pkg::DISP_REQ;
			end
			tlic_pkg::DISP_REQ: begin
				if (I_IRQ_ACK) begin
					next_in_service[lvl] = 1'b1;
					next_req             = 1'b0;
					next_state           = tlic_pkg::DISP_IDLE;
				end else begin
					// withdrawn or outranked requests are replaced before the core takes them
					next_req = cand;
					if (!cand)
						next_state = tlic_pkg::DISP_IDLE;
				end
			end
			default: begin
				next_req   = 1'b0;
				next_state = tlic_pkg::DISP_IDLE;
			end
		endcase
		if (next_req && !(state == tlic_pkg::DISP_REQ && I_IRQ_ACK)) begin
			next_lvl    = cand_lvl;
			next_src_id = cand_idx;
			next_vec    = 16'(tlic_pkg::VEC_BASE + (16'(cand_idx) << tlic_pkg::VEC_SHIFT));
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state      <= tlic_pkg::DISP_IDLE;
			req        <= 1'b0;
			lvl        <= tlic_pkg::LVL_LOW;
			src_id     <= 4'h0;
			vec        <= 16'h0000;
			in_service <= 3'h0;
		end else begin
			state      <= next_state;
			req        <= next_req;
			lvl        <= next_lvl;
			src_id     <= next_src_id;
			vec        <= next_vec;
			in_service <= next_in_service;
		end
	end

	// wake pins are asynchronous, so two flops before use
	assign next_wake = I_CORE_HALTED & (|wake_sync);

	always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			wake_meta <= '0;
			wake_sync <= '0;
			wake      <= 1'b0;
		end else begin
			wake_meta <= I_WAKE_PIN;
			wake_sync <= wake_meta;
			wake      <= next_wake;
		end
	end

	assign O_SFR_RDATA  = rdata;
	assign O_SFR_HIT    = hit;
	assign O_BIT_RDATA  = bit_rdata;
	assign O_IRQ_REQ    = req;
	assign O_IRQ_VECTOR = vec;
	assign O_IRQ_LEVEL  = lvl;
	assign O_IRQ_SRC_ID = src_id;
	assign O_IN_SERVICE = in_service;
	assign O_WAKE       = wake;

	// checks on dispatch behaviour and register writes
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);

	property p_global_off;
		!interrupt_enable[tlic_pkg::EN_GLOBAL] |=> !O_IRQ_REQ;
	endproperty
	a_global_off: assert property (p_global_off) else $error("request while global enable clear");

	property p_halted;
		I_CORE_HALTED |=> !O_IRQ_REQ;
	endproperty
	a_halted: assert property (p_halted) else $error("request while core halted");

	property p_pm_preempt;
		pick_pm.found && !in_service[2] && !(O_IRQ_REQ && I_IRQ_ACK)
			|=> O_IRQ_REQ && O_IRQ_LEVEL == tlic_pkg::LVL_PM;
	endproperty
	a_pm_preempt: assert property (p_pm_preempt) else $error("power request not dispatched");

	property p_above_service;
		O_IRQ_REQ |-> (in_service >> O_IRQ_LEVEL) == 3'h0;
	endproperty
	a_above_service: assert property (p_above_service) else $error("request not above service level");

	property p_high_first;
		!pick_pm.found && pick_hi.found && pick_lo.found && in_service == 3'h0 && !(O_IRQ_REQ && I_IRQ_ACK)
			|=> O_IRQ_REQ && O_IRQ_LEVEL == tlic_pkg::LVL_HIGH;
	endproperty
	a_high_first: assert property (p_high_first) else $error("lower level dispatched first");

	property p_poll_low;
		O_IRQ_REQ && O_IRQ_LEVEL == tlic_pkg::LVL_LOW
			|-> ($past(pick_lo.mask) & ((12'h001 << O_IRQ_SRC_ID) - 12'h001)) == 12'h000;
	endproperty
	a_poll_low: assert property (p_poll_low) else $error("polling order broken");

	property p_ack_service;
		O_IRQ_REQ && I_IRQ_ACK && !I_RETI |=> in_service[$past(O_IRQ_LEVEL)] && !O_IRQ_REQ;
	endproperty
	a_ack_service: assert property (p_ack_service) else $error("ack did not enter service");

	property p_reti_pop;
		I_RETI && !(O_IRQ_REQ && I_IRQ_ACK) && in_service != 3'h0
			|=> $countones(in_service) == $countones($past(in_service)) - 1;
	endproperty
	a_reti_pop: assert property (p_reti_pop) else $error("return did not release a level");

	property p_vector;
		O_IRQ_REQ |-> O_IRQ_VECTOR == 16'(tlic_pkg::VEC_BASE + (16'(O_IRQ_SRC_ID) << tlic_pkg::VEC_SHIFT));
	endproperty
	a_vector: assert property (p_vector) else $error("vector does not match source");

	property p_bit_global;
		I_BIT_WR && I_BIT_ADDR == 8'hAF |=> interrupt_enable[tlic_pkg::EN_GLOBAL] == $past(I_BIT_WDATA);
	endproperty
	a_bit_global: assert property (p_bit_global) else $error("bit write to global enable lost");

	property p_en2_fixed;
		I_SFR_WR && I_SFR_ADDR == tlic_pkg::ADDR_EN2
			|=> (secondary_enable_priority_reg & tlic_pkg::EN2_FIXED) == tlic_pkg::EN2_FIXED;
	endproperty
	a_en2_fixed: assert property (p_en2_fixed) else $error("secondary reserved bits lost");
endmodule : tlic_core

// ==== design/tlic_pick_if.sv ====
`timescale 1ns/1ps
interface tlic_pick_if;
	logic [tlic_pkg::NUM_SRC-1:0]   mask;
	logic                           found;
	logic [tlic_pkg::SRC_IDX_W-1:0] idx;
	modport picker (input mask, output found, output idx);
	modport user (output mask, input found, input idx);
endinterface : tlic_pick_if

// ==== design/tlic_pkg.sv ====
package tlic_pkg;
	// source and level geometry
	localparam int          NUM_SRC   = 12;
	localparam int          SRC_IDX_W = 4;
	localparam int          NUM_LVL   = 3;
	localparam logic [1:0]  LVL_LOW   = 2'h0;
	localparam logic [1:0]  LVL_HIGH  = 2'h1;
	localparam logic [1:0]  LVL_PM    = 2'h2;
	// source index doubles as the polling position, zero polled first
	localparam logic [3:0]  SRC_PM    = 4'h0;
	localparam logic [3:0]  SRC_TK    = 4'h1;
	localparam logic [3:0]  SRC_METER = 4'h2;
	localparam logic [3:0]  SRC_WDOG  = 4'h3;
	localparam logic [3:0]  SRC_X0    = 4'h4;
	localparam logic [3:0]  SRC_T0    = 4'h5;
	localparam logic [3:0]  SRC_X1    = 4'h6;
	localparam logic [3:0]  SRC_T1    = 4'h7;
	localparam logic [3:0]  SRC_SI    = 4'h8;
	localparam logic [3:0]  SRC_SP    = 4'h9;
	localparam logic [3:0]  SRC_T2    = 4'hA;
	localparam logic [3:0]  SRC_AUX   = 4'hB;
	// special function register addresses
	localparam logic [7:0]  ADDR_EN    = 8'hA8;
	localparam logic [7:0]  ADDR_EN2   = 8'hA9;
	localparam logic [7:0]  ADDR_PRIO  = 8'hB8;
	localparam logic [7:0]  ADDR_WDCTL = 8'hC0;
	localparam logic [7:0]  BIT_BASE_MASK = 8'hF8;
	// reset values
	localparam logic [7:0]  RST_EN    = 8'h00;
	localparam logic [7:0]  RST_EN2   = 8'hA0;
	localparam logic [7:0]  RST_PRIO  = 8'h00;
	localparam logic [7:0]  RST_WDCTL = 8'h10;
	localparam logic [7:0]  EN2_FIXED = 8'hA0;
	// enable register fields
	localparam int          EN_GLOBAL = 7;
	localparam int          EN_T2     = 5;
	localparam int          EN_SP     = 4;
	localparam int          EN_T1     = 3;
	localparam int          EN_X1     = 2;
	localparam int          EN_T0     = 1;
	localparam int          EN_X0     = 0;
	// priority register fields
	localparam int          PR_METER  = 7;
	localparam int          PR_T2     = 5;
	localparam int          PR_SP     = 4;
	localparam int          PR_T1     = 3;
	localparam int          PR_X1     = 2;
	localparam int          PR_T0     = 1;
	localparam int          PR_X0     = 0;
	// secondary enable and priority fields
	localparam int          E2_TK_PRIO = 6;
	localparam int          E2_SI_PRIO = 4;
	localparam int          E2_METER   = 3;
	localparam int          E2_TK      = 2;
	localparam int          E2_PM      = 1;
	localparam int          E2_SI      = 0;
	// watchdog control: interrupt enable position
	localparam int          WD_IRQ_EN  = 5;
	// vector table: base plus eight bytes per source
	localparam logic [15:0] VEC_BASE   = 16'h0003;
	localparam int          VEC_SHIFT  = 3;
	// dispatch handshake states
	typedef enum logic {
		DISP_IDLE = 1'b0,
		DISP_REQ  = 1'b1
	} tlic_disp_type;
endpackage : tlic_pkg

// ==== design/tlic_poll_pick.sv ====
`timescale 1ns/1ps
module tlic_poll_pick (
	tlic_pick_if.picker pick
);
	// scan downward so the lowest index, polled first, wins the tie
	always_comb begin
		pick.found = 1'b0;
		pick.idx   = '0;
		for (int i = tlic_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (pick.mask[i]) begin
				pick.found = 1'b1;
				pick.idx   = tlic_pkg::SRC_IDX_W'(i);
			end
		end
	end
endmodule : tlic_poll_pick

// ==== dv/tlic_core_partner.sv ====
`timescale 1ns/1ps
// processor core side: takes a request promptly or after a few cycles
module tlic_core_partner (
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	input  wire logic i_irq_req,
	input  wire logic i_slow,
	output logic      o_irq_ack
);
	logic [1:0] wait_cnt;
	logic [1:0] next_wait_cnt;
	logic       next_ack;

	// ack is a one-cycle pulse, raised only while the request is up
	always_comb begin
		next_ack      = 1'b0;
		next_wait_cnt = wait_cnt;
		if (i_irq_req && !o_irq_ack) begin
			if (!i_slow || wait_cnt == 2'h3) begin
				next_ack      = 1'b1;
				next_wait_cnt = 2'h0;
			end else begin
				next_wait_cnt = wait_cnt + 2'h1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq_ack <= 1'b0;
			wait_cnt  <= 2'h0;
		end else begin
			o_irq_ack <= next_ack;
			wait_cnt  <= next_wait_cnt;
		end
	end
endmodule : tlic_core_partner

// ==== dv/tlic_core_test.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module tlic_core_test;
	typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; logic h; } tlic_row_type;
	logic        clk, rst_n, sfr_wr, sfr_rd, bit_wdata, bit_wr, halted, ack, reti, slow;
	logic [7:0]  sfr_addr, sfr_wdata, bit_addr, rdata;
	logic [11:0] src;
	logic [1:0]  wake, lvl;
	logic        hit, bit_rdata, req, wake_seen;
	logic [15:0] vec;
	logic [3:0]  sid;
	logic [2:0]  in_svc;
	int          n_errors = 0;
	int          cmp_count = 0;
	// writes then readbacks; the table also leaves every enable but the watchdog one set
	tlic_row_type rows [7] = '{
		'{8'hA9, 8'h5F, 8'hFF, 1'b1},
		'{8'hA9, 8'h0F, 8'hAF, 1'b1},
		'{8'hB8, 8'hA5, 8'hA5, 1'b1},
		'{8'hB8, 8'h00, 8'h00, 1'b1},
		'{8'hA8, 8'hBF, 8'hBF, 1'b1},
		'{8'h90, 8'h55, 8'h00, 1'b0},
		'{8'hC8, 8'hAA, 8'h00, 1'b0}};

	tlic_core #(.NUM_WAKE(2)) tlic_core_inst (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_SFR_ADDR(sfr_addr),
		.I_SFR_WDATA(sfr_wdata), .I_SFR_WR(sfr_wr), .I_SFR_RD(sfr_rd), .O_SFR_RDATA(rdata), .O_SFR_HIT(hit),
		.I_BIT_ADDR(bit_addr), .I_BIT_WDATA(bit_wdata), .I_BIT_WR(bit_wr), .O_BIT_RDATA(bit_rdata),
		.I_IRQ_SRC(src), .I_CORE_HALTED(halted), .I_WAKE_PIN(wake), .I_IRQ_ACK(ack), .I_RETI(reti),
		.O_IRQ_REQ(req), .O_IRQ_VECTOR(vec), .O_IRQ_LEVEL(lvl), .O_IRQ_SRC_ID(sid), .O_IN_SERVICE(in_svc),
		.O_WAKE(wake_seen));
	tlic_core_partner tlic_core_partner_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_irq_req(req),
		.i_slow(slow), .o_irq_ack(ack));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict

	// bus tasks start and end on a falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
		@(negedge clk);
		sfr_addr = a; sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		`CHK("rdata", e, rdata)
		`CHK("hit", h, hit)
	endtask : rd

	task automatic bwr(input logic [7:0] a, input logic v);
		@(negedge clk);
		bit_addr = a; bit_wdata = v; bit_wr = 1'b1;
		@(negedge clk);
		bit_wr = 1'b0;
	endtask : bwr

	task automatic brd(input logic [7:0] a, input logic e);
		@(negedge clk);
		bit_addr = a;
		@(negedge clk);
		`CHK("bit_rdata", e, bit_rdata)
	endtask : brd

	// bounded wait for a request, then its fields
	task automatic wait_req(input logic [3:0] id, input logic [1:0] l);
		int i;
		i = 0;
		while (req !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		`CHK("req", 1'b1, req)
		`CHK("src_id", id, sid)
		`CHK("level", l, lvl)
		`CHK("vector", tlic_pkg::VEC_BASE + ({12'h000, id} << tlic_pkg::VEC_SHIFT), vec)
	endtask : wait_req

	// the partner acks; request drops as the level goes in service
	task automatic serve(input logic [2:0] is);
		int i;
		i = 0;
		while (req !== 1'b0 && i < 20) begin
			@(negedge clk);
			i++;
		end
		`CHK("in_service", is, in_svc)
	endtask : serve

	task automatic reti_pulse(input logic [2:0] is);
		@(negedge clk);
		reti = 1'b1;
		@(negedge clk);
		reti = 1'b0;
		`CHK("in_service", is, in_svc)
	endtask : reti_pulse

	task automatic none(input int n);
		repeat (n) begin
			@(negedge clk);
			`CHK("quiet", 1'b0, req)
		end
	endtask : none

	initial begin
		repeat (3000) @(posedge clk);
		n_errors++;
		print_verdict();
	end

	initial begin
		rst_n = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0;
		bit_addr = 8'h00; bit_wdata = 1'b0; bit_wr = 1'b0; src = 12'h000; halted = 1'b0;
		wake = 2'b00; reti = 1'b0; slow = 1'b0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		`CHK("req", 1'b0, req)
		rd(8'hA8, 8'h00, 1'b1);
		rd(8'hA9, 8'hA0, 1'b1);
		rd(8'hB8, 8'h00, 1'b1);
		rd(8'hC0, 8'h10, 1'b1);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e, rows[i].h);
		end
		bwr(8'hC5, 1'b1); // watchdog source enable
		brd(8'hA9, 1'b1);
		// each source wins over all later ones, then is served and returned
		for (int k = 0; k < 12; k++) begin
			src = 12'hFFF << k;
			wait_req(k[3:0], (k == 0) ? tlic_pkg::LVL_PM : tlic_pkg::LVL_LOW);
			serve((k == 0) ? 3'b100 : 3'b001);
			src = 12'h000;
			reti_pulse(3'b000);
		end
		// nested levels: timer 2 and timekeeping moved up
		wr(8'hB8, 8'h20);
		wr(8'hA9, 8'h4F);
		src = 12'h410;
		wait_req(tlic_pkg::SRC_T2, tlic_pkg::LVL_HIGH);
		serve(3'b010);
		src = 12'h412;
		none(6);
		src = 12'h413;
		wait_req(tlic_pkg::SRC_PM, tlic_pkg::LVL_PM);
		serve(3'b110);
		src = 12'h412;
		reti_pulse(3'b010);
		slow = 1'b1;
		reti_pulse(3'b000);
		wait_req(tlic_pkg::SRC_TK, tlic_pkg::LVL_HIGH);
		serve(3'b010);
		slow = 1'b0;
		src = 12'h010;
		reti_pulse(3'b000);
		wait_req(tlic_pkg::SRC_X0, tlic_pkg::LVL_LOW);
		serve(3'b001);
		src = 12'h410;
		wait_req(tlic_pkg::SRC_T2, tlic_pkg::LVL_HIGH);
		serve(3'b011);
		src = 12'h000;
		reti_pulse(3'b001);
		reti_pulse(3'b000);
		// gating: global enable off, then one source enable off
		bwr(8'hAF, 1'b0);
		brd(8'hAF, 1'b0);
		src = 12'h010;
		none(5);
		bwr(8'hA8, 1'b0);
		bwr(8'hAF, 1'b1);
		none(5);
		src = 12'h030;
		wait_req(tlic_pkg::SRC_T0, tlic_pkg::LVL_LOW);
		serve(3'b001);
		src = 12'h000;
		reti_pulse(3'b000);
		// halted core: no interrupt, but a wake pin gets through
		halted = 1'b1;
		src = 12'h020;
		none(4);
		wake = 2'b01;
		@(negedge clk);
		`CHK("wake", 1'b0, wake_seen)
		repeat (3) @(negedge clk);
		`CHK("wake", 1'b1, wake_seen)
		wake = 2'b00;
		halted = 1'b0;
		wait_req(tlic_pkg::SRC_T0, tlic_pkg::LVL_LOW);
		serve(3'b001);
		// reset in mid-service clears the in-service state
		rst_n = 1'b0;
		@(negedge clk);
		`CHK("in_service", 3'b000, in_svc)
		`CHK("req", 1'b0, req)
		src = 12'h000;
		rst_n = 1'b1;
		rd(8'hA8, 8'h00, 1'b1);
		print_verdict();
	end
endmodule : tlic_core_test
